/* File: fpx_params.svh */
/*
  fpx_params.svh: offsets, field positions, reset values and vector numbers
  of the floating-point exception signalling block.
  assumes: included by bare name; definitions only.
*/
`ifndef FPX_PARAMS_SVH
`define FPX_PARAMS_SVH

// register offsets (word addresses on the plain register port)
`define FPX_OFF_CTRL     4'h0
`define FPX_OFF_VCSR     4'h1
`define FPX_OFF_IRQ_STAT 4'h2
`define FPX_OFF_IRQ_MASK 4'h3
`define FPX_OFF_STATUS   4'h4

// main control register fields
`define FPX_CTRL_NATIVE_BIT 5

// vector control/status fields: flags [5:0], masks [11:6]
`define FPX_VFLAG_LSB    0
`define FPX_VMASK_LSB    6
`define FPX_NEXC         6

// reset values
`define FPX_CTRL_RST     32'h0000_0000
`define FPX_VCSR_RST     12'hfc0
`define FPX_IMASK_RST    4'h0

// vector numbers
`define FPX_VEC_LEGACY   8'h10
`define FPX_VEC_VECTOR   8'h13

// interrupt status bits
`define FPX_IRQ_LEGACY_LATCH 0
`define FPX_IRQ_LEGACY_TAKEN 1
`define FPX_IRQ_VEC_FAULT    2
`define FPX_IRQ_VEC_MASKED   3
`define FPX_NIRQ             4

`endif

/* File: fpx_pkg.sv */
/*
  fpx_pkg.sv: types of the floating-point exception signalling block.
  assumes: fpx_params.svh is on the include path.
*/
`include "fpx_params.svh"

package fpx_pkg;

  typedef logic [`FPX_NEXC-1:0] fpx_exc_t;

  // one legacy scalar instruction step from the core
  typedef struct packed {
    logic     valid;
    logic     waiting;
    logic     raises;
    fpx_exc_t unmasked;
  } fpx_legacy_s;

  // one vector instruction completion, up to four lanes
  typedef struct packed {
    logic                    valid;
    logic [3:0][`FPX_NEXC-1:0] lane_exc;
  } fpx_vec_s;

  // exception taken by the core
  typedef struct packed {
    logic       take;
    logic [7:0] vector;
  } fpx_trap_s;

  typedef enum logic [2:0] {
    FPX_IDLE    = 3'b001,
    FPX_PENDING = 3'b010,
    FPX_TAKE    = 3'b100
  } fpx_leg_state_e;

endpackage : fpx_pkg

/* File: fpx_legacy.sv */
/*
  fpx_legacy.sv: deferred error tracking of the legacy scalar unit.
  assumes: same clock as the top; instruction steps are one-cycle strobes.
*/
`timescale 1ns/100ps
`include "fpx_params.svh"

module fpx_legacy (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // control
  input  wire logic              native_error_mode_bit,
  input  wire fpx_pkg::fpx_legacy_s step,
  // results
  output logic                   pending,
  output logic                   take,
  output logic                   latched
);
  import fpx_pkg::*;

  fpx_leg_state_e state;
  fpx_leg_state_e next_state;

  always_comb begin
    next_state = state;
    take       = 1'b0;
    latched    = 1'b0;
    case (state)
      FPX_IDLE: begin
        if (step.valid && step.raises && (|step.unmasked)) begin
          next_state = FPX_PENDING;  // [RULE2]
          latched    = 1'b1;
        end
      end
      FPX_PENDING: begin
        // no-wait steps pass by and leave it pending [RULE14] [RULE4]
        if (step.valid && step.waiting && native_error_mode_bit) begin
          take       = 1'b1;  // [RULE2] [RULE5]
          next_state = FPX_TAKE;
        end
      end
      FPX_TAKE: begin
        next_state = FPX_IDLE;  // handler clears the error state
      end
      default: next_state = FPX_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= FPX_IDLE;
    end else begin
      state <= next_state;
    end
  end

  assign pending = (state == FPX_PENDING);

endmodule : fpx_legacy

/* File: fpx_vector.sv */
/*
  fpx_vector.sv: flag merge and mask check of a vector instruction.
  assumes: combinational; lanes beyond the operand count carry zeros.
*/
`timescale 1ns/100ps
`include "fpx_params.svh"

module fpx_vector (
  // inputs
  input  wire fpx_pkg::fpx_vec_s vec,
  input  wire fpx_pkg::fpx_exc_t mask,
  // results
  output fpx_pkg::fpx_exc_t      merged,
  output logic                   fault
);
  import fpx_pkg::*;

  // one flag set per instruction, lane identity dropped
  genvar g;
  generate
    for (g = 0; g < `FPX_NEXC; g++) begin : g_or
      assign merged[g] = vec.valid & (vec.lane_exc[0][g] | vec.lane_exc[1][g]
                         | vec.lane_exc[2][g] | vec.lane_exc[3][g]);  // [RULE13] [RULE8]
    end
  endgenerate

  // only a new exceptional operation counts, never an old sticky flag
  assign fault = |(merged & ~mask);  // [RULE9] [RULE11]

endmodule : fpx_vector

/* File: fpx_top.sv */
/*
  fpx_top.sv: floating-point exception signalling, legacy deferred errors
  and precise vector faults, with registers on a plain port.
  assumes: core presents instruction steps as one-cycle strobes on clk;
  single clock, asynchronous active-high reset.
*/
// The implementer's own choices: the address-and-strobe port and the register offsets.
// Overview of operation
// [RULE1] native error mode bit set to one selects internal error reporting
// [RULE2] unmasked legacy error latched; vector 16 taken before next waiting step; the code drops it when a vector fault wins the same cycle
// [RULE3] error output pin asserts on unmasked error in both modes alike
// [RULE4] native mode never takes vector 16 on a non-waiting step
// [RULE5] native mode delivers internally, no external delay path
// [RULE6] software keeps the external error interrupt line disabled
// [RULE7] masked vector exception gives default result, sticky flag, no signal
// [RULE8] packed vector ops keep one flag set, no lane record
// [RULE9] unmasked vector exception raises the vector fault, vector 19
// [RULE10] vector faults are precise, on the faulting instruction itself
// [RULE11] set sticky flag with clear mask never faults by itself
// [RULE12] software sets the descriptor entry for vector 19 first
// [RULE13] packed flags are the OR of all lane flags
// [RULE14] non-waiting step completes, legacy error stays pending
// [RULE15] native bit zero: no vector 16, error pin only
// [RULE16] taking a vector fault leaves sticky flags unchanged
`timescale 1ns/100ps
`include "fpx_params.svh"

module fpx_top (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // register port
  input  wire logic [3:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [31:0]          reg_rdata,
  // core instruction flow
  input  wire fpx_pkg::fpx_legacy_s legacy_step,
  input  wire fpx_pkg::fpx_vec_s    vec_done,
  // exception delivery
  output fpx_pkg::fpx_trap_s        trap,
  output logic                      fp_error_out_pin,
  output logic                      vec_default_result,
  output logic                      irq
);
  import fpx_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // state
  logic [31:0]          main_control_register;
  logic [11:0]          vector_fp_control_status;
  logic [`FPX_NIRQ-1:0] irq_stat;
  logic [`FPX_NIRQ-1:0] irq_mask;

  logic [31:0]          next_ctrl;
  logic [11:0]          next_vcsr;
  logic [`FPX_NIRQ-1:0] next_stat;
  logic [`FPX_NIRQ-1:0] next_mask;
  logic [31:0]          next_rdata;
  fpx_trap_s            next_trap;
  logic                 next_err;
  logic                 next_dflt;
  logic                 next_irq;

  logic                 native;
  logic                 leg_pending;
  logic                 leg_take;
  logic                 leg_latched;
  fpx_exc_t             vmerged;
  logic                 vfault;
  fpx_exc_t             vmask;
  logic [`FPX_NIRQ-1:0] events;

  assign native = main_control_register[`FPX_CTRL_NATIVE_BIT];  // [RULE1]
  assign vmask  = vector_fp_control_status[`FPX_VMASK_LSB +: `FPX_NEXC];

  //////////////////////////////////////////////////////////////////////////
  // engines
  fpx_legacy u_legacy (
    .clk                   (clk),
    .rst                   (rst),
    .native_error_mode_bit (native),
    .step                  (legacy_step),
    .pending               (leg_pending),
    .take                  (leg_take),
    .latched               (leg_latched)
  );

  fpx_vector u_vector (
    .vec    (vec_done),
    .mask   (vmask),
    .merged (vmerged),
    .fault  (vfault)
  );

  //////////////////////////////////////////////////////////////////////////
  // write decode, one strobe per writable register
  logic                 wr_ctrl;
  logic                 wr_vcsr;
  logic                 wr_stat;
  logic                 wr_mask;

  always_comb begin
    wr_ctrl = 1'b0;
    wr_vcsr = 1'b0;
    wr_stat = 1'b0;
    wr_mask = 1'b0;
    if (reg_wr) begin
      if (reg_addr == `FPX_OFF_CTRL) begin
        wr_ctrl = 1'b1;
      end else if (reg_addr == `FPX_OFF_VCSR) begin
        wr_vcsr = 1'b1;
      end else if (reg_addr == `FPX_OFF_IRQ_STAT) begin
        wr_stat = 1'b1;
      end else if (reg_addr == `FPX_OFF_IRQ_MASK) begin
        wr_mask = 1'b1;
      end
      // unmapped indices and the read-only status word drop the write
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // main control register: the native error mode bit lives here
  always_comb begin
    next_ctrl = main_control_register;
    if (wr_ctrl) begin
      next_ctrl = reg_wdata;  // [RULE1]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      main_control_register <= `FPX_CTRL_RST;
    end else begin
      main_control_register <= next_ctrl;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // vector control/status: masks and sticky flags
  always_comb begin
    next_vcsr = vector_fp_control_status;
    if (wr_vcsr) begin
      next_vcsr = reg_wdata[11:0];  // the only way flags are cleared [RULE16]
    end
    // flags set whether masked or not, and a fault leaves them alone; a new
    // flag still lands when software rewrites the register in that cycle
    next_vcsr[`FPX_VFLAG_LSB +: `FPX_NEXC] =
      next_vcsr[`FPX_VFLAG_LSB +: `FPX_NEXC] | vmerged;  // [RULE7] [RULE16]
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      vector_fp_control_status <= `FPX_VCSR_RST;
    end else begin
      vector_fp_control_status <= next_vcsr;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // interrupt events, one bit per kind
  always_comb begin
    events                        = '0;
    events[`FPX_IRQ_LEGACY_LATCH] = leg_latched;
    events[`FPX_IRQ_LEGACY_TAKEN] = leg_take;
    events[`FPX_IRQ_VEC_FAULT]    = vfault;
    events[`FPX_IRQ_VEC_MASKED]   = (|vmerged) & ~vfault;
  end

  //////////////////////////////////////////////////////////////////////////
  // interrupt status, write one to clear
  always_comb begin
    next_stat = irq_stat;
    if (wr_stat) begin
      next_stat = irq_stat & ~reg_wdata[`FPX_NIRQ-1:0];
    end
    // set beats a same-cycle clear, so an event is never lost to a race
    next_stat = next_stat | events;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_stat <= '0;
    end else begin
      irq_stat <= next_stat;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // interrupt mask, same layout as the status
  always_comb begin
    next_mask = irq_mask;
    if (wr_mask) begin
      next_mask = reg_wdata[`FPX_NIRQ-1:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_mask <= `FPX_IMASK_RST;
    end else begin
      irq_mask <= next_mask;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read port: data stand one cycle after the strobe, zero otherwise
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (reg_rd) begin
      if (reg_addr == `FPX_OFF_CTRL) begin
        next_rdata = main_control_register;
      end else if (reg_addr == `FPX_OFF_VCSR) begin
        next_rdata = {20'h0_0000, vector_fp_control_status};
      end else if (reg_addr == `FPX_OFF_IRQ_STAT) begin
        next_rdata = {28'h000_0000, irq_stat};
      end else if (reg_addr == `FPX_OFF_IRQ_MASK) begin
        next_rdata = {28'h000_0000, irq_mask};
      end else if (reg_addr == `FPX_OFF_STATUS) begin
        // lets software see the pin even while its external path is shut
        next_rdata = {30'h0, fp_error_out_pin, leg_pending};
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // exception delivery to the core
  always_comb begin
    next_trap = '0;
    // the vector fault wins: it belongs to the instruction now completing,
    // while the legacy error has already waited; that legacy take is lost
    if (vfault) begin
      next_trap.take   = 1'b1;  // [RULE9] [RULE10]
      next_trap.vector = `FPX_VEC_VECTOR;
    end else if (leg_take) begin
      // internal, one cycle after the waiting step, no external path [RULE5]
      next_trap.take   = 1'b1;  // [RULE2] [RULE15]
      next_trap.vector = `FPX_VEC_LEGACY;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trap <= '0;
    end else begin
      trap <= next_trap;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // error output pin: high from the latch until the trap is taken
  always_comb begin
    // same instruction point in both modes; keeping its external path shut
    // in native mode is left to software
    next_err = leg_latched | (leg_pending & ~leg_take);  // [RULE3] [RULE15]
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fp_error_out_pin <= 1'b0;
    end else begin
      fp_error_out_pin <= next_err;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // default result pulse of a masked vector exception; no trap, only a status event
  always_comb begin
    next_dflt = (|vmerged) & ~vfault;  // [RULE7]
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      vec_default_result <= 1'b0;
    end else begin
      vec_default_result <= next_dflt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // interrupt line, taken from the next state so it moves with the status
  always_comb begin
    next_irq = |(next_stat & next_mask);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end

endmodule : fpx_top

/* File: fpx_props.sv */
/* fpx_props.sv: concurrent checks on the ports of fpx_top.
   assumes: bound to fpx_top; one clock, async active-high reset. */
`timescale 1ns/100ps
`include "fpx_params.svh"
module fpx_props (
  // clock and reset
  input wire logic                 clk,
  input wire logic                 rst,
  // register writes
  input wire logic [3:0]           reg_addr,
  input wire logic [31:0]          reg_wdata,
  input wire logic                 reg_wr,
  // instruction flow and delivery
  input wire fpx_pkg::fpx_legacy_s legacy_step,
  input wire fpx_pkg::fpx_vec_s    vec_done,
  input wire fpx_pkg::fpx_trap_s   trap,
  input wire logic                 fp_error_out_pin,
  input wire logic                 vec_default_result
);
  import fpx_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic native_q, next_native, leg_take, vec_take;
  assign leg_take = trap.take && trap.vector == `FPX_VEC_LEGACY;
  assign vec_take = trap.take && trap.vector == `FPX_VEC_VECTOR;
  // shadow of the mode bit, so legacy traps can be judged against it
  always_comb begin
    next_native = native_q;
    if (reg_wr && reg_addr == `FPX_OFF_CTRL) next_native = reg_wdata[`FPX_CTRL_NATIVE_BIT];
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) native_q <= 1'b0;
    else native_q <= next_native;
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence s_wait_pend;
    legacy_step.valid && legacy_step.waiting && fp_error_out_pin && native_q;
  endsequence
  sequence s_quiet;
    !vec_done.valid && !reg_wr;
  endsequence
  a_pin_cause: assert property ($rose(fp_error_out_pin) |->
    $past(legacy_step.valid && legacy_step.raises && (|legacy_step.unmasked)))
    else $error("error pin rose without an erring step");
  a_leg_take_why: assert property (leg_take |-> !fp_error_out_pin &&
    $past(legacy_step.valid && legacy_step.waiting && fp_error_out_pin))
    else $error("legacy trap without a waiting step");
  a_leg_take_due: assert property (s_wait_pend ##0 s_quiet |=> leg_take)
    else $error("legacy trap missing after waiting step");
  a_nowait_hold: assert property (legacy_step.valid && !legacy_step.waiting &&
    fp_error_out_pin |=> fp_error_out_pin && !leg_take)
    else $error("no-wait step disturbed the pending error");
  a_native_only: assert property (leg_take |-> $past(native_q))
    else $error("legacy trap with native mode off");
  a_vec_precise: assert property (vec_take |-> $past(vec_done.valid))
    else $error("vector fault not on its instruction");
  a_vec_answer: assert property (vec_done.valid && |vec_done.lane_exc |=>
    vec_take || vec_default_result)
    else $error("vector exception gave no response");
  a_vec_quiet: assert property (!vec_done.valid |=> !vec_take && !vec_default_result)
    else $error("vector response without instruction");
endmodule : fpx_props

/* File: fpx_pic_model.sv */
/* fpx_pic_model.sv: interrupt controller and handler software beside fpx_top.
   assumes: bench drives native_sw to match the mode bit it writes. */
`timescale 1ns/100ps
module fpx_pic_model (
  // clock and reset
  input wire logic               clk,
  input wire logic               rst,
  // device side
  input wire logic               native_sw,
  input wire logic               fp_error_out_pin,
  input wire fpx_pkg::fpx_trap_s trap,
  // observed results
  output logic                   ext_req,
  output logic [3:0]             n_vec19
);
  import fpx_pkg::*;
  // software masks the external error line whenever native reporting runs
  assign ext_req = fp_error_out_pin & ~native_sw;
  // the fault descriptor is in place from reset, before any unmasked fault
  always_ff @(posedge clk or posedge rst) begin
    if (rst) n_vec19 <= 4'h0;
    else if (trap.take && trap.vector == 8'h13) n_vec19 <= n_vec19 + 4'h1;
  end
endmodule : fpx_pic_model

/* File: test_fp_exception_signalling.sv */
/* test_fp_exception_signalling.sv: self-checking bench of fpx_top.
   assumes: package, checker and controller model compiled first. */
`timescale 1ns/100ps
module test_fp_exception_signalling;
  import fpx_pkg::*;
  logic        clk, rst, reg_wr, reg_rd, irq, pin, vdef, native_sw, ext_req;
  logic [3:0]  reg_addr, n_vec19;
  logic [31:0] reg_wdata, reg_rdata, seed, acc;
  fpx_legacy_s legacy_step;
  fpx_vec_s    vec_done;
  fpx_trap_s   trap;
  logic [8:0]  notes[$];
  int          n_fail, comparisons;
  fpx_top dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .legacy_step(legacy_step),
    .vec_done(vec_done), .trap(trap), .fp_error_out_pin(pin), .vec_default_result(vdef),
    .irq(irq));
  fpx_pic_model pic (.clk(clk), .rst(rst), .native_sw(native_sw), .fp_error_out_pin(pin),
    .trap(trap), .ext_req(ext_req), .n_vec19(n_vec19));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task automatic fail(input string m);
    n_fail++;
    $display("ERROR %0t %s", $time, m);
  endtask : fail
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) fail("value differs");
  endtask : chk
  task automatic end_sim;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask : rd
  // a non-zero note is the event that must follow; 0ff stands for a default result
  task automatic lstep(input logic w, input logic r, input logic [5:0] u, input logic [8:0] n);
    @(posedge clk);
    legacy_step <= {1'b1, w, r, u};
    if (n != 9'h0) notes.push_back(n);
    @(posedge clk);
    legacy_step <= '0;
  endtask : lstep
  task automatic vstep(input logic [23:0] l, input logic [8:0] n);
    @(posedge clk);
    vec_done <= {1'b1, l};
    if (n != 9'h0) notes.push_back(n);
    @(posedge clk);
    vec_done <= '0;
  endtask : vstep
  task automatic irq_is(input logic e);
    repeat (2) @(posedge clk);
    #1 chk({31'h0, irq}, {31'h0, e});
  endtask : irq_is
  ////////////////////////////////////////////////////////////////////////////
  always @(negedge clk) begin
    if (!rst && (trap.take !== 1'b0 || vdef !== 1'b0)) begin
      comparisons++;
      if (notes.size() == 0) fail("exception not expected");
      else if ((trap.take ? {1'b1, trap.vector} : 9'h0ff) !== notes.pop_front())
        fail("wrong exception");
    end
  end
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (3000) @(posedge clk);
    fail("run did not finish");
    end_sim;
  end
  initial begin
    {rst, reg_wr, reg_rd, native_sw} = 4'h8;
    {reg_addr, reg_wdata, acc} = '0;
    legacy_step = '0;
    vec_done = '0;
    seed = 32'h8587;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(4'h0, 32'h0);
    rd(4'h1, 32'hfc0);
    rd(4'h3, 32'h0);
    rd(4'h4, 32'h0);
    seed = xs(seed);
    wr({1'b1, seed[2:0]}, seed);
    rd({1'b1, seed[2:0]}, 32'h0);
    lstep(1'b1, 1'b1, 6'h01, 9'h0);
    rd(4'h4, 32'h3);
    lstep(1'b1, 1'b0, 6'h00, 9'h0);
    rd(4'h4, 32'h3);
    chk({31'h0, ext_req}, 32'h1);
    wr(4'h0, 32'h20);
    native_sw <= 1'b1;
    lstep(1'b0, 1'b0, 6'h00, 9'h0);
    chk({31'h0, ext_req}, 32'h0);
    lstep(1'b1, 1'b0, 6'h00, 9'h110);
    rd(4'h4, 32'h0);
    seed = xs(seed);
    lstep(1'b1, 1'b1, seed[5:0] | 6'h01, 9'h0);
    rd(4'h4, 32'h3);
    lstep(1'b1, 1'b0, 6'h00, 9'h110);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      acc[5:0] = acc[5:0] | seed[5:0] | seed[11:6] | seed[17:12] | seed[23:18];
      vstep(seed[23:0], (|seed[23:0]) ? 9'h0ff : 9'h0);
    end
    rd(4'h1, 32'hfc0 | acc);
    wr(4'h1, 32'hf80);
    vstep(24'h001000, 9'h113);
    irq_is(1'b0);
    rd(4'h1, 32'hf81);
    vstep(24'h000000, 9'h0);
    vstep(24'h080000, 9'h0ff);
    rd(4'h1, 32'hf83);
    wr(4'h3, 32'h4);
    irq_is(1'b1);
    rd(4'h2, 32'hf);
    wr(4'h2, 32'hf);
    irq_is(1'b0);
    rd(4'h2, 32'h0);
    chk({28'h0, n_vec19}, 32'h1);
    if (notes.size() != 0) fail("expected exception never came");
    end_sim;
  end
endmodule : test_fp_exception_signalling
bind fpx_top fpx_props u_props (.clk(clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .legacy_step(legacy_step), .vec_done(vec_done),
  .trap(trap), .fp_error_out_pin(fp_error_out_pin), .vec_default_result(vec_default_result));
